// >>> hdl/urx_if.sv
// Interface carrying the sampled line and recovered characters
`timescale 1ns/1ps
`default_nettype none
interface urx_if;
    logic tick;
    logic rxd;
    logic nine;
    logic done;
    logic [9:0] shift;
    logic noise;
    logic framing;
    logic idle_bit;
    logic busy;
    modport core (input tick, input rxd, input nine, output done, output shift,
        output noise, output framing, output idle_bit, output busy);
    modport host (output tick, output rxd, output nine, input done, input shift,
        input noise, input framing, input idle_bit, input busy);
endinterface
`default_nettype wire

// >>> hdl/urx_pkg.sv
// Package of constants and types for the serial receiver block
// Summary of operation
// R1 - Sample input at sixteen times baud
// R2 - Resync tick counter at start and falling edges
// R3 - Start search: zero after three ones
// R4 - Verify start at ticks 3,5,7
// R5 - Failed verification restarts start search
// R6 - Data bit is majority of 8,9,10
// R7 - Start ones at 8-10 set noise only
// R8 - Stop bit majority zero sets framing
// R9 - Framing fault set with receive-full
// R10 - Standby suppresses all receiver interrupt requests
// R11 - Address mark wakes and sets full
// R12 - Idle wakes without quiet or full
// R13 - Standby on idle line may end immediately
// R14 - Transfer to holding sets receive-full flag
// R15 - Quiet flag after 10/11 ones
// R16 - Overrun keeps old, drops new, flags
// R17 - Noise on any bit sets noise
// R18 - Framing fault requests fault interrupt
// R19 - Parity mismatch sets parity fault
// R20 - Keeps running in wait; irq wakes
// R21 - Software disables unit before wait
// R22 - Stop mode freezes, keeps registers; the recovery core drops back to start search
// R23 - Break sets framing, full, break; clears data
// R24 - Ninth bit stored; copies bit 7
// R25 - Two-flop synchroniser on serial input
package urx_pkg;
    localparam logic [3:0] URX_OFS_CTRL1 = 4'h0;
    localparam logic [3:0] URX_OFS_CTRL2 = 4'h4;
    localparam logic [3:0] URX_OFS_CTRL3 = 4'h8;
    localparam logic [3:0] URX_OFS_STAT1 = 4'hc;
    localparam int URX_ADDR_W = 4;
    // Control one: enable, 9-bit, wake, quiet type, parity enable, odd
    localparam int C1_EN = 0;
    localparam int C1_NINE = 1;
    localparam int C1_WAKE = 2;
    localparam int C1_QTY = 3;
    localparam int C1_PEN = 4;
    localparam int C1_ODD = 5;
    // Control two: full ie, quiet ie, receiver enable, standby request
    localparam int C2_RFIE = 0;
    localparam int C2_QIE = 1;
    localparam int C2_RE = 2;
    localparam int C2_SBY = 3;
    // Control three: ninth bit (ro), lost/noise/framing/parity ie
    localparam int C3_BIT8 = 0;
    localparam int C3_LIE = 1;
    localparam int C3_NIE = 2;
    localparam int C3_FIE = 3;
    localparam int C3_PIE = 4;
    // Status: full, quiet, lost, noise, framing, parity, break, busy
    localparam int S_FULL = 0;
    localparam int S_QUIET = 1;
    localparam int S_LOST = 2;
    localparam int S_NOISE = 3;
    localparam int S_FRM = 4;
    localparam int S_PAR = 5;
    localparam int S_BRK = 6;
    localparam int S_BUSY = 7;
    localparam int URX_DATA_LSB = 8;
    localparam int URX_OVERSAMPLE = 16;
    localparam logic [3:0] TK_V1 = 4'h2;
    localparam logic [3:0] TK_V2 = 4'h4;
    localparam logic [3:0] TK_V3 = 4'h6;
    localparam logic [3:0] TK_D1 = 4'h7;
    localparam logic [3:0] TK_D2 = 4'h8;
    localparam logic [3:0] TK_D3 = 4'h9;
    localparam logic [3:0] TK_LAST = 4'hf;
    localparam logic [3:0] URX_BITS8 = 4'h8;
    localparam logic [3:0] URX_BITS9 = 4'h9;
    localparam logic [3:0] URX_QUIET8 = 4'ha;
    localparam logic [3:0] URX_QUIET9 = 4'hb;
    localparam logic [15:0] URX_DIV_RST = 16'h0001;
    typedef enum logic [1:0] {URX_HUNT, URX_START, URX_BITS} urx_state_e;
endpackage

// >>> hdl/urx_recover.sv
// Data recovery core: start search, majority sampling, stop check
`timescale 1ns/1ps
`default_nettype none
module urx_recover (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    urx_if.core lk
);
    typedef struct packed {
        urx_pkg::urx_state_e st;
        logic [3:0] tk;
        logic [2:0] hist;
        logic [2:0] smp;
        logic [3:0] nbit;
        logic [9:0] sh;
        logic nz;
        logic prev;
        logic done;
        logic frm;
        logic ib;
    } urx_core_s;
    urx_core_s s_reg, s_next;
    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    function automatic logic dis3(input logic [2:0] v);
        return (v != 3'h0) && (v != 3'h7);
    endfunction
    logic [2:0] ts;
    logic b;
    logic [3:0] nlast;
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.ib = 1'b0;
        ts = {s_reg.smp[1:0], lk.rxd};
        b = maj3(ts);
        nlast = lk.nine ? urx_pkg::URX_BITS9 : urx_pkg::URX_BITS8;
        if (!enable) begin
            s_next.st = urx_pkg::URX_HUNT;
            s_next.hist = 3'h0;
        end else if (lk.tick) begin
            s_next.tk = s_reg.tk + 4'h1;
            case (s_reg.st)
                urx_pkg::URX_HUNT: begin
                    s_next.hist = {s_reg.hist[1:0], lk.rxd};
                    // Falling edge after three ones starts the count
                    if (s_reg.hist == 3'h7 && !lk.rxd) begin // R3
                        s_next.st = urx_pkg::URX_START;
                        s_next.tk = 4'h1; // R2
                        s_next.nz = 1'b0;
                        s_next.smp = 3'h0;
                    end
                end
                urx_pkg::URX_START: begin
                    if (s_reg.tk == urx_pkg::TK_V1 || s_reg.tk == urx_pkg::TK_V2 ||
                        s_reg.tk == urx_pkg::TK_V3) begin
                        s_next.smp = {s_reg.smp[1:0], lk.rxd};
                    end
                    if (s_reg.tk == urx_pkg::TK_V3) begin
                        if (b) begin // R4 R5
                            s_next.st = urx_pkg::URX_HUNT;
                            s_next.hist = 3'h0;
                        end else if (dis3(ts)) begin
                            s_next.nz = 1'b1; // R4
                        end
                    end
                    if (s_reg.tk >= urx_pkg::TK_D1 && s_reg.tk <= urx_pkg::TK_D3 &&
                        lk.rxd) begin
                        s_next.nz = 1'b1; // R7
                    end
                    if (s_reg.tk == urx_pkg::TK_LAST) begin
                        s_next.st = urx_pkg::URX_BITS;
                        s_next.nbit = 4'h0;
                        s_next.prev = 1'b0;
                    end
                end
                default: begin
                    s_next.hist = {s_reg.hist[1:0], lk.rxd};
                    // Realign on a line fall after a decided 1, never inside the sample window
                    if (s_reg.prev && s_reg.hist[0] && !lk.rxd &&
                        (s_reg.tk > urx_pkg::TK_D3 || s_reg.tk < urx_pkg::TK_D1)) begin
                        s_next.tk = 4'h1; // R2
                    end
                    if (s_reg.tk >= urx_pkg::TK_D1 && s_reg.tk <= urx_pkg::TK_D3) begin
                        s_next.smp = {s_reg.smp[1:0], lk.rxd};
                    end
                    if (s_reg.tk == urx_pkg::TK_D3) begin
                        s_next.nz = s_reg.nz | dis3(ts); // R6 R8 R17
                        s_next.sh = {b, s_reg.sh[9:1]}; // R6
                        s_next.prev = b;
                        s_next.ib = b;
                        if (s_reg.nbit == nlast) begin
                            s_next.frm = !b; // R8 R9
                            s_next.done = 1'b1;
                            s_next.st = urx_pkg::URX_HUNT;
                            s_next.hist = 3'h0;
                            s_next.ib = 1'b0;
                        end else begin
                            s_next.nbit = s_reg.nbit + 4'h1;
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign lk.done = s_reg.done;
    assign lk.shift = s_reg.sh;
    assign lk.noise = s_reg.nz;
    assign lk.framing = s_reg.frm;
    assign lk.idle_bit = s_reg.ib;
    assign lk.busy = (s_reg.st != urx_pkg::URX_HUNT);
    a_hunt_restart: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == urx_pkg::URX_START && lk.tick && s_reg.tk == urx_pkg::TK_V3 && b)
        |=> s_reg.st == urx_pkg::URX_HUNT) else $error("start not rejected"); // R5
    a_frame_done: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.done |-> s_reg.frm == !s_reg.sh[9]) else $error("framing mismatch"); // R8
    a_start_seen: assert property (@(posedge ref_clk) disable iff (rst) // R3
        (enable && lk.tick && s_reg.st == urx_pkg::URX_HUNT && s_reg.hist == 3'h7 &&
        !lk.rxd) |=> s_reg.st == urx_pkg::URX_START && s_reg.tk == 4'h1)
        else $error("start edge missed");
endmodule
`default_nettype wire

// >>> hdl/urx_top.sv
// Serial receiver top: AHB-Lite registers, flags, standby and interrupts
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module urx_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rxd_pin,
    input wire logic stop_mode,
    output logic rx_irq,
    output logic fault_irq
);
    typedef struct packed {
        logic [1:0] sy;
        logic [15:0] div;
        logic tick;
        logic [5:0] c1;
        logic [3:0] c2;
        logic [4:0] c3;
        logic [7:0] st;
        logic [7:0] data;
        logic [3:0] ones;
        logic armed;
        logic wr;
        logic rd;
        logic [3:0] wa;
        logic [31:0] rdat;
        logic rxi;
        logic fli;
        logic stat_seen;
        logic [3:0] sub;
    } urx_top_s;
    urx_top_s s_reg, s_next;
    parameter logic [15:0] URX_DIV = urx_pkg::URX_DIV_RST;
    logic [15:0] rate_div;
    urx_if lk();
    assign rate_div = URX_DIV;
    urx_recover u_rec (
        .ref_clk(ref_clk),
        .rst(rst),
        .enable(s_reg.c1[urx_pkg::C1_EN] & s_reg.c2[urx_pkg::C2_RE] & !stop_mode),
        .lk(lk)
    );
    assign lk.tick = s_reg.tick & !stop_mode; // R22
    assign lk.rxd = s_reg.sy[1];
    assign lk.nine = s_reg.c1[urx_pkg::C1_NINE];
    logic take;
    logic hi_ok;
    logic [7:0] rx_byte;
    logic par_bad;
    logic msb;
    logic [3:0] qlim;
    always_comb begin
        s_next = s_reg;
        take = hsel & hready & htrans[1];
        // Only the first block of offsets is mapped; aliases read zero
        hi_ok = (haddr[31:urx_pkg::URX_ADDR_W] == 28'h0);
        rx_byte = s_reg.c1[urx_pkg::C1_NINE] ? lk.shift[7:0] : lk.shift[8:1];
        s_next.sy = {s_reg.sy[0], rxd_pin}; // R25
        s_next.tick = 1'b0;
        // Baud divider yields sixteen ticks per bit
        if (!stop_mode && s_reg.c1[urx_pkg::C1_EN]) begin
            if (s_reg.div >= rate_div - 16'h0001) begin
                s_next.div = 16'h0000;
                s_next.tick = 1'b1; // R1
            end else begin
                s_next.div = s_reg.div + 16'h0001;
            end
        end
        s_next.wr = take & hwrite & hi_ok;
        s_next.rd = take & !hwrite & hi_ok;
        s_next.wa = haddr[urx_pkg::URX_ADDR_W-1:0];
        if (take && !hwrite) begin
            if (!hi_ok) begin
                s_next.rdat = 32'h0;
            end else if (haddr[3:0] == urx_pkg::URX_OFS_CTRL1) begin
                s_next.rdat = {26'h0, s_reg.c1};
            end else if (haddr[3:0] == urx_pkg::URX_OFS_CTRL2) begin
                s_next.rdat = {28'h0, s_reg.c2};
            end else if (haddr[3:0] == urx_pkg::URX_OFS_CTRL3) begin
                s_next.rdat = {27'h0, s_reg.c3};
            end else if (haddr[3:0] == urx_pkg::URX_OFS_STAT1) begin
                s_next.rdat = {16'h0, s_reg.data, s_reg.st[7:1], s_reg.st[0]} |
                    {24'h0, lk.busy, 7'h0};
                s_next.stat_seen = 1'b1;
            end else begin
                s_next.rdat = 32'h0;
            end
        end
        // Status clears: a status read arms, then clears bits 6:0 itself on the next cycle
        if (s_reg.rd && s_reg.wa == urx_pkg::URX_OFS_STAT1 && s_reg.stat_seen) begin
            s_next.st[6:0] = 7'h0;
            s_next.stat_seen = 1'b0;
        end
        if (s_reg.wr) begin
            if (s_reg.wa == urx_pkg::URX_OFS_CTRL1) begin
                s_next.c1 = hwdata[5:0];
            end else if (s_reg.wa == urx_pkg::URX_OFS_CTRL2) begin
                s_next.c2 = hwdata[3:0];
            end else if (s_reg.wa == urx_pkg::URX_OFS_CTRL3) begin
                s_next.c3[4:1] = hwdata[4:1];
            end
        end
        // Quiet line counting: whole bit times of high line while hunting, plus decided 1 bits of a character when quiet type is clear
        qlim = s_reg.c1[urx_pkg::C1_NINE] ? urx_pkg::URX_QUIET9 : urx_pkg::URX_QUIET8;
        if (lk.done) begin
            s_next.ones = 4'h0;
            s_next.sub = 4'h0;
            s_next.armed = 1'b1;
        end else if (lk.busy) begin
            s_next.sub = 4'h0;
            if (lk.idle_bit && !s_reg.c1[urx_pkg::C1_QTY]) begin
                s_next.ones = (s_reg.ones == 4'hf) ? s_reg.ones : s_reg.ones + 4'h1; // R12
            end
        end else if (lk.tick) begin
            if (!s_reg.sy[1]) begin
                s_next.ones = 4'h0;
                s_next.sub = 4'h0;
            end else if (s_reg.sub == urx_pkg::TK_LAST) begin
                s_next.sub = 4'h0;
                s_next.ones = (s_reg.ones == 4'hf) ? s_reg.ones : s_reg.ones + 4'h1; // R15
            end else begin
                s_next.sub = s_reg.sub + 4'h1;
            end
        end
        // Top data bit sits at shift[8] in both character lengths
        msb = lk.shift[8];
        par_bad = s_reg.c1[urx_pkg::C1_PEN] &
            ((^(s_reg.c1[urx_pkg::C1_NINE] ? lk.shift[8:0] : {1'b0, lk.shift[8:1]}))
            ^ s_reg.c1[urx_pkg::C1_ODD]);
        // An idle line wakes standby even before any character, so a late
        // standby request on a quiet line ends at once
        if (s_reg.c2[urx_pkg::C2_SBY] && !s_reg.c1[urx_pkg::C1_WAKE] && s_reg.ones >= qlim) begin
            s_next.c2[urx_pkg::C2_SBY] = 1'b0; // R12 R13
            s_next.armed = 1'b0;
        end else if (s_reg.armed && s_reg.ones >= qlim) begin
            s_next.armed = 1'b0;
            s_next.st[urx_pkg::S_QUIET] = 1'b1; // R15
        end
        if (lk.done) begin
            if (s_reg.c2[urx_pkg::C2_SBY]) begin
                if (s_reg.c1[urx_pkg::C1_WAKE] && msb) begin
                    s_next.c2[urx_pkg::C2_SBY] = 1'b0; // R11
                    s_next.st[urx_pkg::S_FULL] = 1'b1;
                    s_next.data = rx_byte;
                end
            end else if (s_reg.st[urx_pkg::S_FULL]) begin
                s_next.st[urx_pkg::S_LOST] = 1'b1; // R16
            end else begin
                s_next.st[urx_pkg::S_FULL] = 1'b1; // R14
                s_next.st[urx_pkg::S_FRM] = lk.framing; // R9 R18
                s_next.st[urx_pkg::S_NOISE] = s_reg.st[urx_pkg::S_NOISE] | lk.noise; // R17
                s_next.st[urx_pkg::S_PAR] = s_reg.st[urx_pkg::S_PAR] | par_bad; // R19
                s_next.data = rx_byte;
                s_next.c3[urx_pkg::C3_BIT8] = lk.shift[8]; // R24
                if (lk.framing && lk.shift[9:1] == 9'h0 &&
                    (!s_reg.c1[urx_pkg::C1_NINE] || !lk.shift[0])) begin
                    s_next.st[urx_pkg::S_BRK] = 1'b1; // R23
                    s_next.data = 8'h00;
                    s_next.c3[urx_pkg::C3_BIT8] = 1'b0;
                end
            end
        end
        // Standby masks every receiver request
        s_next.rxi = !s_reg.c2[urx_pkg::C2_SBY] &
            ((s_reg.st[urx_pkg::S_FULL] & s_reg.c2[urx_pkg::C2_RFIE]) |
            (s_reg.st[urx_pkg::S_QUIET] & s_reg.c2[urx_pkg::C2_QIE])); // R10 R14 R20
        s_next.fli = !s_reg.c2[urx_pkg::C2_SBY] &
            ((s_reg.st[urx_pkg::S_LOST] & s_reg.c3[urx_pkg::C3_LIE]) |
            (s_reg.st[urx_pkg::S_NOISE] & s_reg.c3[urx_pkg::C3_NIE]) |
            (s_reg.st[urx_pkg::S_FRM] & s_reg.c3[urx_pkg::C3_FIE]) |
            (s_reg.st[urx_pkg::S_PAR] & s_reg.c3[urx_pkg::C3_PIE])); // R10 R18 R19
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign hrdata = s_reg.rdat;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rx_irq = s_reg.rxi;
    assign fault_irq = s_reg.fli;
    a_standby_mask: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.c2[urx_pkg::C2_SBY] |=> !rx_irq) else $error("irq in standby"); // R10
    a_overrun_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (lk.done && s_reg.st[urx_pkg::S_FULL] && !s_reg.c2[urx_pkg::C2_SBY])
        |=> s_reg.st[urx_pkg::S_LOST] && $stable(s_reg.data)) else $error("overrun"); // R16
    a_full_framing: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (lk.done && !s_reg.st[urx_pkg::S_FULL] && !s_reg.c2[urx_pkg::C2_SBY])
        |=> s_reg.st[urx_pkg::S_FULL] && s_reg.st[urx_pkg::S_FRM] == $past(lk.framing))
        else $error("framing not set with full");
endmodule
`default_nettype wire

// >>> tb/test_uart_receiver_data_recovery.sv
// Self-checking testbench for the serial receiver block
`timescale 1ns/1ps
`default_nettype none
module test_uart_receiver_data_recovery;
    localparam int DIV = 1;
    localparam int BT = 16 * DIV;
    localparam int FU = 1 << urx_pkg::S_FULL;
    localparam int QU = 1 << urx_pkg::S_QUIET;
    localparam int LO = 1 << urx_pkg::S_LOST;
    localparam int NO = 1 << urx_pkg::S_NOISE;
    localparam int FR = 1 << urx_pkg::S_FRM;
    localparam int PA = 1 << urx_pkg::S_PAR;
    localparam int BR = 1 << urx_pkg::S_BRK;
    // Busy is left out of the mask: its timing is not pinned down
    localparam logic [31:0] SM = 32'hff7f;
    localparam logic [31:0] A1 = 32'(urx_pkg::URX_OFS_CTRL1);
    localparam logic [31:0] A2 = 32'(urx_pkg::URX_OFS_CTRL2);
    localparam logic [31:0] A3 = 32'(urx_pkg::URX_OFS_CTRL3);
    localparam logic [31:0] AS = 32'(urx_pkg::URX_OFS_STAT1);
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic stop_mode = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic rx_irq;
    logic fault_irq;
    logic rxd_pin;
    logic [31:0] rd;
    int error_cnt = 0;
    int check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    urx_line_model #(.DIV(DIV)) line (.ref_clk(ref_clk), .rxd(rxd_pin));

    urx_top #(.URX_DIV(16'(DIV))) uut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxd_pin(rxd_pin), .stop_mode(stop_mode),
        .rx_irq(rx_irq), .fault_irq(fault_irq)
    );

    // ****************
    // Checks and bus access
    // ****************
    task automatic chk_reg(input logic [31:0] got, exp, mask);
        check_count++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("mismatch at %0t: reg %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sv(input logic [7:0] d, input int f);
        return (32'(d) << urx_pkg::URX_DATA_LSB) | 32'(f);
    endfunction

    task automatic bus(input logic w, input logic [31:0] a, wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
        chk_bit(hresp, 1'b0);
    endtask

    task automatic stat(input logic [31:0] exp, mask);
        bus(1'b0, AS, 32'h0);
        chk_reg(rd, exp, mask);
    endtask

    // Fresh reset per scenario so one read of status sees clean flags
    task automatic restart(input logic [31:0] c1, c2, c3);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b1, A1, c1);
        bus(1'b1, A2, c2);
        bus(1'b1, A3, c3);
        repeat (4 * BT) @(posedge ref_clk);
    endtask

    task automatic ch8(input logic [7:0] d, input int nb);
        line.send({3'b111, d, 1'b0}, 10, nb);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        restart(32'h1, 32'h6, 32'h0);
        ch8(8'ha5, -1);
        chk_bit(rx_irq, 1'b0);
        repeat (12 * BT) @(posedge ref_clk);
        chk_bit(rx_irq, 1'b1);
        stat(sv(8'ha5, FU | QU), SM);
        bus(1'b0, A3, 32'h0);
        chk_reg(rd, 32'h1, 32'h1);
        stop_mode <= 1'b1;
        repeat (50) @(posedge ref_clk);
        stop_mode <= 1'b0;
        bus(1'b0, A2, 32'h0);
        chk_reg(rd, 32'h6, 32'hf);
        bus(1'b1, A1, 32'h0);
        bus(1'b0, A1, 32'h0);
        chk_reg(rd, 32'h0, 32'h3f);
        bus(1'b1, 32'h14, 32'hff);
        bus(1'b0, 32'h14, 32'h0);
        chk_reg(rd, 32'h0, 32'hffffffff);
        // Glitch on one data sample
        restart(32'h1, 32'h4, 32'h4);
        ch8(8'h3c, 3);
        stat(sv(8'h3c, FU | NO), SM);
        chk_bit(fault_irq, 1'b1);
        // Low stop bit
        restart(32'h1, 32'h4, 32'h8);
        line.send({2'b11, 1'b0, 8'h55, 1'b0}, 10, -1);
        repeat (4) @(posedge ref_clk);
        stat(sv(8'h55, FU | FR), SM);
        chk_bit(fault_irq, 1'b1);
        // Break character
        restart(32'h1, 32'h4, 32'h0);
        line.send(12'h0, 10, -1);
        repeat (4) @(posedge ref_clk);
        stat(sv(8'h00, FU | FR | BR), SM);
        // Second character before the first is read
        restart(32'h1, 32'h4, 32'h2);
        ch8(8'h11, -1);
        ch8(8'h22, -1);
        stat(sv(8'h11, FU | LO), SM);
        chk_bit(fault_irq, 1'b1);
        // Too short a start, then a real character
        restart(32'h1, 32'h5, 32'h0);
        line.low_pulse(2);
        repeat (3 * BT) @(posedge ref_clk);
        chk_bit(rx_irq, 1'b0);
        ch8(8'h96, -1);
        stat(sv(8'h96, FU), SM);
        // Even parity expected, odd parity sent
        restart(32'h11, 32'h4, 32'h10);
        line.send({3'b111, 1'b1, 7'h03, 1'b0}, 10, -1);
        repeat (4) @(posedge ref_clk);
        stat(sv(8'h00, FU | PA), 32'(FU | PA));
        chk_bit(fault_irq, 1'b1);
        // Nine-bit character with bit 8 clear and bit 7 set
        restart(32'h3, 32'h4, 32'h0);
        line.send({2'b11, 1'b0, 8'hff, 1'b0}, 11, -1);
        repeat (4) @(posedge ref_clk);
        stat(sv(8'hff, FU), 32'hff01);
        bus(1'b0, A3, 32'h0);
        chk_reg(rd, 32'h0, 32'h1);
        // Standby with address-mark wakeup
        restart(32'h5, 32'hd, 32'h0);
        ch8(8'h12, -1);
        chk_bit(rx_irq, 1'b0);
        ch8(8'h81, -1);
        bus(1'b0, A2, 32'h0);
        chk_reg(rd, 32'h5, 32'hf);
        chk_bit(rx_irq, 1'b1);
        stat(sv(8'h81, FU), 32'hff01);
        // Standby with idle-line wakeup on an already idle line
        restart(32'h1, 32'he, 32'h0);
        repeat (12 * BT) @(posedge ref_clk);
        bus(1'b0, A2, 32'h0);
        chk_reg(rd, 32'h6, 32'hf);
        finish_test();
    end
endmodule
`default_nettype wire

// >>> tb/urx_line_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module urx_line_model #(
    parameter int DIV = 1
) (
    input wire logic ref_clk,
    output logic rxd
);
    // ****************
    // Line driver
    // ****************
    // Line idles high between frames, as a real transmitter leaves it
    initial rxd = 1'b1;

    // Bits go out lsb first, sixteen ticks each; bit nb gets one flipped tick
    task automatic send(input logic [11:0] fr, input int n, input int nb);
        for (int b = 0; b < n; b++) begin
            for (int t = 0; t < 16 * DIV; t++) begin
                @(posedge ref_clk);
                rxd <= (b == nb && t / DIV == 8) ? ~fr[b] : fr[b];
            end
        end
        @(posedge ref_clk);
        rxd <= 1'b1;
    endtask

    // Short low glitch that looks like a start edge but is too brief
    task automatic low_pulse(input int ticks);
        @(posedge ref_clk);
        rxd <= 1'b0;
        repeat (ticks * DIV) @(posedge ref_clk);
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire
